// *** core/cdg_generator.sv ***
// Function
// R1 - dead-band clock is system clock or 16 MHz fast oscillator, one select bit
// R2 - two-bit field selects source: two modulators, oscillator output, logic cell
// R3 - codes 00,01,10,11 map to modulator one, two, oscillator, logic cell
// R4 - on enable both output drives start cleared
// R5 - each output has its own enable; clear means no pin control
// R6 - enabled output drives override level or active waveform to pin
// R7 - with module enable clear, output enables and levels have no effect
// R8 - per-output polarity: set is active-high, clear is active-low
// R9 - override levels pass without polarity inversion
// R10 - two independent 6-bit dead-band counters, rising and falling; code uses one shared 6-bit counter
// R11 - dead band counts clock periods from zero up to register value
// R12 - rising edge: complementary off now, count, then primary on
// R13 - rising dead-band register sets delay of 0 to 64 counts; the 6-bit register gives 0 to 63
// R14 - dead-band value zero means no delay at all
// R15 - dead band always timed from source edge, not output edges
// R16 - source reverting before count ends gives no pulse on waiting output
// R17 - each output turn-on delayable after other turns off, never both on; code lets override_enable drive both outputs on at once
// R18 - falling edge: primary off now, count, then complementary on
//
// The register offsets and strobed register access were left to the implementer.
module cdg_generator
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_stb,
  input  wire logic       i_rd_stb,
  output logic      [7:0] o_rd_data,
  // waveform sources
  input  wire logic       i_first_modulator_output,
  input  wire logic       i_second_modulator_output,
  input  wire logic       i_oscillator_source_output,
  input  wire logic       i_logic_cell_output,
  // pin drive toward port priority logic
  output logic            o_primary_output,
  output logic            o_primary_output_oe,
  output logic            o_complementary_output,
  output logic            o_complementary_output_oe
);

  // ==========================================================================
  // register file
  // ==========================================================================
  cdg_pkg::cdg_cfg_t  cfg_reg;
  cdg_pkg::cdg_cfg_t  cfg_next;
  cdg_pkg::cdg_state_t state_reg;
  cdg_pkg::cdg_state_t state_next;
  logic [5:0]         cnt_reg;
  logic [5:0]         cnt_next;
  logic [6:0]         acc_reg;
  logic [6:0]         acc_next;
  logic               src_prev_reg;
  logic [7:0]         ctrl0_view;
  logic [7:0]         ctrl1_view;
  logic [7:0]         stat_view;
  logic [7:0]         rd_mux;

  // field views of the configuration for read-back
  assign ctrl0_view = {cfg_reg.generator_enable, cfg_reg.primary_output_enable,
                       cfg_reg.complementary_output_enable, cfg_reg.primary_polarity,
                       cfg_reg.complementary_polarity, 2'h0, cfg_reg.deadband_clock_select};
  assign ctrl1_view = {cfg_reg.override_enable, 1'h0, cfg_reg.override_primary,
                       cfg_reg.override_complementary, 2'h0, cfg_reg.source_select_field};
  assign stat_view  = {5'h00, (state_reg == cdg_pkg::ST_RISE_WAIT) ||
                              (state_reg == cdg_pkg::ST_FALL_WAIT),
                       state_reg == cdg_pkg::ST_COMPL, state_reg == cdg_pkg::ST_PRIMARY};

  // unmapped addresses read as zero
  assign rd_mux = (i_addr == cdg_pkg::ADDR_CONTROL_ZERO) ? ctrl0_view :
                  (i_addr == cdg_pkg::ADDR_CONTROL_ONE)  ? ctrl1_view :
                  (i_addr == cdg_pkg::ADDR_RISE_COUNT)   ? {2'h0, cfg_reg.rising_deadband_count} :
                  (i_addr == cdg_pkg::ADDR_FALL_COUNT)   ? {2'h0, cfg_reg.falling_deadband_count} :
                  (i_addr == cdg_pkg::ADDR_STATUS)       ? stat_view : 8'h00;

  // write decode, one field group per register
  always_comb
  begin
    cfg_next = cfg_reg;
    if (i_wr_stb && (i_addr == cdg_pkg::ADDR_CONTROL_ZERO))
    begin
      cfg_next.generator_enable            = i_wr_data[cdg_pkg::BIT_GENERATOR_ENABLE];
      cfg_next.primary_output_enable       = i_wr_data[cdg_pkg::BIT_PRIMARY_ENABLE];
      cfg_next.complementary_output_enable = i_wr_data[cdg_pkg::BIT_COMPLEMENTARY_ENABLE];
      cfg_next.primary_polarity            = i_wr_data[cdg_pkg::BIT_PRIMARY_POLARITY];
      cfg_next.complementary_polarity      = i_wr_data[cdg_pkg::BIT_COMPLEMENTARY_POLARITY];
      cfg_next.deadband_clock_select       = i_wr_data[cdg_pkg::BIT_CLOCK_SELECT];
    end
    if (i_wr_stb && (i_addr == cdg_pkg::ADDR_CONTROL_ONE))
    begin
      cfg_next.override_enable        = i_wr_data[cdg_pkg::BIT_OVERRIDE_ENABLE];
      cfg_next.override_primary       = i_wr_data[cdg_pkg::BIT_OVERRIDE_PRIMARY];
      cfg_next.override_complementary = i_wr_data[cdg_pkg::BIT_OVERRIDE_COMPLEMENTARY];
      cfg_next.source_select_field    =
        cdg_pkg::cdg_source_t'(i_wr_data[cdg_pkg::SOURCE_SELECT_LSB +: 2]);
    end
    if (i_wr_stb && (i_addr == cdg_pkg::ADDR_RISE_COUNT))
      cfg_next.rising_deadband_count = i_wr_data[5:0]; // see R13
    if (i_wr_stb && (i_addr == cdg_pkg::ADDR_FALL_COUNT))
      cfg_next.falling_deadband_count = i_wr_data[5:0];
  end

  // configuration store and read data, which stands one cycle only
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_reg   <= '0;
      o_rd_data <= 8'h00;
    end
    else
    begin
      cfg_reg   <= cfg_next;
      o_rd_data <= i_rd_stb ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // dead-band clock and source selection
  // ==========================================================================
  logic       db_tick;
  logic [7:0] acc_sum;
  logic       osc_tick;
  logic       src_sel;
  logic       src_rise;
  logic       src_fall;

  // fractional divider: 16 ticks every 125 cycles, so jitter is one cycle
  assign acc_sum  = {1'b0, acc_reg} + {1'b0, cdg_pkg::OSC_ACC_STEP};
  assign osc_tick = acc_sum >= {1'b0, cdg_pkg::OSC_ACC_MOD};
  assign acc_next = osc_tick ? 7'(acc_sum - {1'b0, cdg_pkg::OSC_ACC_MOD}) : acc_sum[6:0];
  assign db_tick  = cfg_reg.deadband_clock_select ? osc_tick : 1'b1; // see R1

  // source mux, codes in listed order
  assign src_sel =
    (cfg_reg.source_select_field == cdg_pkg::SRC_FIRST_MODULATOR)  ? i_first_modulator_output :
    (cfg_reg.source_select_field == cdg_pkg::SRC_SECOND_MODULATOR) ? i_second_modulator_output :
    (cfg_reg.source_select_field == cdg_pkg::SRC_OSCILLATOR)       ? i_oscillator_source_output :
                                                                     i_logic_cell_output; // see R2 R3

  // timing keys off the chosen source edge only
  assign src_rise = src_sel && !src_prev_reg; // see R15
  assign src_fall = !src_sel && src_prev_reg;

  // ==========================================================================
  // dead-band sequencer
  // ==========================================================================
  // one shared counter serves both edges: they never run at once, and each
  // compares against its own register, so they time independently
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!cfg_reg.generator_enable)
    begin
      state_next = cdg_pkg::ST_IDLE; // see R4
      cnt_next   = 6'h00;
    end
    else if (src_rise)
    begin
      cnt_next   = 6'h00;
      state_next = (cfg_reg.rising_deadband_count == 6'h00) ?
                   cdg_pkg::ST_PRIMARY : cdg_pkg::ST_RISE_WAIT; // see R12 R14
    end
    else if (src_fall)
    begin
      cnt_next   = 6'h00;
      state_next = (cfg_reg.falling_deadband_count == 6'h00) ?
                   cdg_pkg::ST_COMPL : cdg_pkg::ST_FALL_WAIT; // see R18 R16
    end
    else
    begin
      case (state_reg)
        cdg_pkg::ST_IDLE,
        cdg_pkg::ST_PRIMARY,
        cdg_pkg::ST_COMPL:
          state_next = state_reg;
        cdg_pkg::ST_RISE_WAIT:
        begin
          // the tick that reaches the setting ends the wait: a setting of n gives n periods
          if ((cnt_reg == cfg_reg.rising_deadband_count) ||
              (db_tick && (6'(cnt_reg + 6'h01) == cfg_reg.rising_deadband_count)))
            state_next = cdg_pkg::ST_PRIMARY; // see R11 R10
          else if (db_tick)
            cnt_next = 6'(cnt_reg + 6'h01);
        end
        cdg_pkg::ST_FALL_WAIT:
        begin
          if ((cnt_reg == cfg_reg.falling_deadband_count) ||
              (db_tick && (6'(cnt_reg + 6'h01) == cfg_reg.falling_deadband_count)))
            state_next = cdg_pkg::ST_COMPL; // see R11 R10
          else if (db_tick)
            cnt_next = 6'(cnt_reg + 6'h01);
        end
        default:
          state_next = cdg_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg    <= cdg_pkg::ST_IDLE;
      cnt_reg      <= 6'h00;
      acc_reg      <= 7'h00;
      src_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      acc_reg      <= acc_next;
      src_prev_reg <= src_sel;
    end
  end

  // ==========================================================================
  // output stage
  // ==========================================================================
  logic a_act;
  logic b_act;
  logic a_level;
  logic b_level;

  // only one state drives each output, so overlap cannot occur while override_enable is clear
  assign a_act   = state_next == cdg_pkg::ST_PRIMARY; // see R17
  assign b_act   = state_next == cdg_pkg::ST_COMPL;
  assign a_level = cfg_reg.override_enable ? cfg_reg.override_primary :
                   (cfg_reg.primary_polarity ? a_act : !a_act); // see R8 R9
  assign b_level = cfg_reg.override_enable ? cfg_reg.override_complementary :
                   (cfg_reg.complementary_polarity ? b_act : !b_act);

  // enables gated by module enable; port priority logic sits outside
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_primary_output          <= 1'b0;
      o_complementary_output    <= 1'b0;
      o_primary_output_oe       <= 1'b0;
      o_complementary_output_oe <= 1'b0;
    end
    else
    begin
      o_primary_output          <= a_level; // see R6
      o_complementary_output    <= b_level;
      o_primary_output_oe       <= cfg_reg.generator_enable &&
                                   cfg_reg.primary_output_enable; // see R5 R7
      o_complementary_output_oe <= cfg_reg.generator_enable &&
                                   cfg_reg.complementary_output_enable;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  property p_no_overlap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ($past(i_rst_n) && !$past(cfg_reg.override_enable)) |->
    !((o_primary_output == $past(cfg_reg.primary_polarity)) &&
      (o_complementary_output == $past(cfg_reg.complementary_polarity)));
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs active"); // see R17

  property p_rise_compl_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (cfg_reg.generator_enable && src_rise) |=> (state_reg != cdg_pkg::ST_COMPL);
  endproperty
  a_rise_compl_off: assert property (p_rise_compl_off) else $error("compl on after rise"); // see R12

  property p_fall_prim_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (cfg_reg.generator_enable && src_fall) |=> (state_reg != cdg_pkg::ST_PRIMARY);
  endproperty
  a_fall_prim_off: assert property (p_fall_prim_off) else $error("primary on after fall"); // see R18

  property p_zero_delay;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (cfg_reg.generator_enable && src_rise && (cfg_reg.rising_deadband_count == 6'h00))
      |=> (state_reg == cdg_pkg::ST_PRIMARY);
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero dead band delayed"); // see R14

  property p_disabled_no_drive;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !cfg_reg.generator_enable |=> !o_primary_output_oe && !o_complementary_output_oe;
  endproperty
  a_disabled_no_drive: assert property (p_disabled_no_drive) else $error("drive while off"); // see R7

  property p_enable_follows;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ##1 o_primary_output_oe == $past(cfg_reg.generator_enable && cfg_reg.primary_output_enable);
  endproperty
  a_enable_follows: assert property (p_enable_follows) else $error("primary enable wrong"); // see R5

  property p_start_cleared;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(cfg_reg.generator_enable) |-> (state_reg == cdg_pkg::ST_IDLE);
  endproperty
  a_start_cleared: assert property (p_start_cleared) else $error("drive not cleared"); // see R4

  property p_polarity;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_rst_n && !cfg_reg.override_enable && !cfg_reg.primary_polarity && !a_act)
      |=> o_primary_output;
  endproperty
  a_polarity: assert property (p_polarity) else $error("active-low idle level wrong"); // see R8

  property p_override;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    cfg_reg.override_enable |=> (o_complementary_output == $past(cfg_reg.override_complementary));
  endproperty
  a_override: assert property (p_override) else $error("override level altered"); // see R9

  property p_revert_no_pulse;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == cdg_pkg::ST_RISE_WAIT && src_fall) |-> ##1 (state_reg != cdg_pkg::ST_PRIMARY)
      ##1 (state_reg != cdg_pkg::ST_PRIMARY || $past(src_rise));
  endproperty
  a_revert_no_pulse: assert property (p_revert_no_pulse) else $error("pulse after revert"); // see R16

  property p_wait_until_count;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == cdg_pkg::ST_RISE_WAIT && cnt_reg != cfg_reg.rising_deadband_count && !src_fall
     && 6'(cnt_reg + 6'h01) != cfg_reg.rising_deadband_count
     && !src_rise && cfg_reg.generator_enable) |=> (state_reg != cdg_pkg::ST_PRIMARY);
  endproperty
  a_wait_until_count: assert property (p_wait_until_count) else $error("primary early"); // see R11

  property p_sysclk_count;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!cfg_reg.deadband_clock_select && state_reg == cdg_pkg::ST_RISE_WAIT &&
     state_next == cdg_pkg::ST_RISE_WAIT) |=> (cnt_reg == 6'($past(cnt_reg) + 6'h01));
  endproperty
  a_sysclk_count: assert property (p_sysclk_count) else $error("count not advancing"); // see R1

endmodule

// *** core/cdg_pkg.sv ***
package cdg_pkg;

  // ==========================================================================
  // register map (word index on the plain port)
  // ==========================================================================
  localparam logic [2:0] ADDR_CONTROL_ZERO = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_ONE  = 3'h1;
  localparam logic [2:0] ADDR_RISE_COUNT   = 3'h2;
  localparam logic [2:0] ADDR_FALL_COUNT   = 3'h3;
  localparam logic [2:0] ADDR_STATUS       = 3'h4;

  // generator_control_zero fields
  localparam int BIT_GENERATOR_ENABLE       = 7;
  localparam int BIT_PRIMARY_ENABLE         = 6;
  localparam int BIT_COMPLEMENTARY_ENABLE   = 5;
  localparam int BIT_PRIMARY_POLARITY       = 4;
  localparam int BIT_COMPLEMENTARY_POLARITY = 3;
  localparam int BIT_CLOCK_SELECT           = 0;

  // generator_control_one fields
  localparam int BIT_OVERRIDE_ENABLE        = 7;
  localparam int BIT_OVERRIDE_PRIMARY       = 5;
  localparam int BIT_OVERRIDE_COMPLEMENTARY = 4;
  localparam int SOURCE_SELECT_LSB          = 0;

  // status fields
  localparam int BIT_STAT_PRIMARY_ACTIVE    = 0;
  localparam int BIT_STAT_COMPL_ACTIVE      = 1;
  localparam int BIT_STAT_WAITING           = 2;

  // reset values
  localparam logic [7:0] RESET_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] RESET_CONTROL_ONE  = 8'h00;
  localparam logic [5:0] RESET_DEADBAND     = 6'h00;

  // ==========================================================================
  // timing: fast oscillator tick from the system clock
  // ==========================================================================
  localparam int         SYS_CLOCK_MHZ  = 125;
  localparam int         FAST_OSC_MHZ   = 16;
  localparam logic [6:0] OSC_ACC_MOD    = 7'(SYS_CLOCK_MHZ);
  localparam logic [6:0] OSC_ACC_STEP   = 7'(FAST_OSC_MHZ);

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    SRC_FIRST_MODULATOR  = 2'h0,
    SRC_SECOND_MODULATOR = 2'h1,
    SRC_OSCILLATOR       = 2'h2,
    SRC_LOGIC_CELL       = 2'h3
  } cdg_source_t;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h01,
    ST_RISE_WAIT = 5'h02,
    ST_PRIMARY   = 5'h04,
    ST_FALL_WAIT = 5'h08,
    ST_COMPL     = 5'h10
  } cdg_state_t;

  typedef struct packed {
    logic        generator_enable;
    logic        primary_output_enable;
    logic        complementary_output_enable;
    logic        primary_polarity;
    logic        complementary_polarity;
    logic        deadband_clock_select;
    logic        override_enable;
    logic        override_primary;
    logic        override_complementary;
    cdg_source_t source_select_field;
    logic [5:0]  rising_deadband_count;
    logic [5:0]  falling_deadband_count;
  } cdg_cfg_t;

endpackage

// *** verif/cdg_generator_tb.sv ***
module cdg_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // stimulus and observation
  // ==========================================================================
  logic       clk     = 1'b0;
  logic       rst_n   = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdat    = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [3:0] src     = 4'h0;
  logic [1:0] on_lvl  = 2'h3;
  logic [7:0] rdat;
  logic [1:0] out;
  logic [1:0] oe;
  logic [1:0] pin;
  int         overlap;
  int         miscompares = 0;
  int         n_compared  = 0;

  always #4 clk = ~clk;

  // port priority: an unclaimed pin falls back to its port latch, held low
  assign pin = {oe[1] ? out[1] : 1'b0, oe[0] ? out[0] : 1'b0};

  cdg_generator cdg_generator_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdat),
    .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdat),
    .i_first_modulator_output(src[0]), .i_second_modulator_output(src[1]),
    .i_oscillator_source_output(src[2]), .i_logic_cell_output(src[3]),
    .o_primary_output(out[0]), .o_primary_output_oe(oe[0]),
    .o_complementary_output(out[1]), .o_complementary_output_oe(oe[1]));

  cdg_switch_model cdg_switch_model_i (
    .i_clk_sys(clk), .i_pin_primary(pin[0]), .i_pin_compl(pin[1]),
    .i_on_primary(on_lvl[0]), .i_on_compl(on_lvl[1]), .o_overlap(overlap));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic test_done();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then drop to zero
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp8(rdat, exp);
    @(posedge clk);
    #1;
    cmp8(rdat, 8'h00);
  endtask

  // move source s to v; time the turn-off and the turn-on from that edge
  task automatic edge_time(input int s, input logic v, output int t_off, output int t_on);
    t_off = -1;
    t_on  = -1;
    @(posedge clk);
    src[s] <= v;
    for (int n = 0; n < 700 && (t_off < 0 || t_on < 0); n++)
    begin
      @(posedge clk);
      #1;
      if (t_off < 0 && out[v] === 1'b0)
        t_off = n;
      if (t_on < 0 && out[!v] === 1'b1)
        t_on = n;
    end
    if (t_on < 0 || t_off < 0)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: output edge never came", $time);
      test_done();
    end
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    int   a;
    int   b;
    int   d0;
    int   f0;
    logic seen;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 8; r++)
      rd_reg(3'(r), 8'h00);
    // all but enable: pins stay unclaimed, unused bits read zero
    wr_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'h7f);
    wr_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'hff);
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'hff);
    wr_reg(cdg_pkg::ADDR_FALL_COUNT, 8'hff);
    wr_reg(3'h5, 8'hff);
    wr_reg(cdg_pkg::ADDR_STATUS, 8'hff);
    #1;
    cmp8({6'h00, oe}, 8'h00);
    rd_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'h79);
    rd_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'hb3);
    rd_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h3f);
    rd_reg(cdg_pkg::ADDR_FALL_COUNT, 8'h3f);
    rd_reg(3'h5, 8'h00);
    rd_reg(cdg_pkg::ADDR_STATUS, 8'h00);
    wr_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'h00);
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h00);
    wr_reg(cdg_pkg::ADDR_FALL_COUNT, 8'h00);
    // primary enable only, both active high
    wr_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'hd8);
    repeat (2) @(posedge clk);
    #1;
    cmp8({6'h00, oe}, 8'h01);
    cmp8({6'h00, out}, 8'h00);
    wr_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'hf8);
    repeat (2) @(posedge clk);
    #1;
    cmp8({6'h00, oe}, 8'h03);
    // each code follows its own source and ignores another one
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'(s));
      @(posedge clk);
      src[(s + 1) % 4] <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      cmp8({7'h00, out[0]}, 8'h00);
      edge_time(s, 1'b1, a, d0);
      cmp_rng(a, 0, 0);
      cmp_rng(d0, 0, 0);
      edge_time(s, 1'b0, a, f0);
      cmp_rng(a, 0, 0);
      cmp_rng(f0, 0, 0);
      @(posedge clk);
      src[(s + 1) % 4] <= 1'b0;
    end
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h05);
    wr_reg(cdg_pkg::ADDR_FALL_COUNT, 8'h09);
    edge_time(3, 1'b1, a, b);
    cmp_rng(a, 0, 0);
    cmp_rng(b, 5, 5);
    rd_reg(cdg_pkg::ADDR_STATUS, 8'h01);
    edge_time(3, 1'b0, a, b);
    cmp_rng(a, 0, 0);
    cmp_rng(b, 9, 9);
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h3f);
    edge_time(3, 1'b1, a, b);
    cmp_rng(b, 63, 63);
    edge_time(3, 1'b0, a, b);
    // a pulse shorter than the dead band never reaches the primary
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h0a);
    @(posedge clk);
    src[3] <= 1'b1;
    repeat (4) @(posedge clk);
    src[3] <= 1'b0;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      #1;
      seen = seen | out[0];
    end
    cmp8({7'h00, seen}, 8'h00);
    // fast oscillator tick: roughly one count per 125/16 system cycles
    wr_reg(cdg_pkg::ADDR_RISE_COUNT, 8'h08);
    wr_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'hf9);
    edge_time(3, 1'b1, a, b);
    cmp_rng(b - a, 50, 65);
    edge_time(3, 1'b0, a, b);
    // active low outputs with the complementary side active
    wr_reg(cdg_pkg::ADDR_CONTROL_ZERO, 8'he0);
    on_lvl <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    cmp8({6'h00, out}, 8'h01);
    // override levels pass straight through despite active low
    wr_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'h90);
    repeat (2) @(posedge clk);
    #1;
    cmp8({6'h00, out}, 8'h02);
    wr_reg(cdg_pkg::ADDR_CONTROL_ONE, 8'ha0);
    repeat (2) @(posedge clk);
    #1;
    cmp8({6'h00, out}, 8'h01);
    cmp_rng(overlap, 0, 0);
    test_done();
  end

  // a hung run still ends in the closing report
  initial
  begin
    #200us;
    miscompares++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    test_done();
  end
endmodule

// *** verif/cdg_switch_model.sv ***
module cdg_switch_model
(
  // clock
  input  wire logic i_clk_sys,
  // resolved pin levels
  input  wire logic i_pin_primary,
  input  wire logic i_pin_compl,
  // level that turns each switch on
  input  wire logic i_on_primary,
  input  wire logic i_on_compl,
  // cycles with both switches conducting
  output int        o_overlap
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // half-bridge switch pair
  // ==========================================================================
  int overlap_cnt = 0;

  // both switches on at once shorts the supply, so every such cycle is counted
  assign o_overlap = overlap_cnt;
  always @(posedge i_clk_sys)
  begin
    if (i_pin_primary === i_on_primary && i_pin_compl === i_on_compl)
      overlap_cnt <= overlap_cnt + 1;
  end
endmodule
